/* File: rtl/ciam_pkg.sv */
// constants for the cyclic io assembly mapper: apb map, layouts, lengths
// assumes one 200 MHz clock and a synchronous active-high reset
// Behaviour
// [R1] poll output layout from vendor attribute one
// [R2] poll output layout from written assembly path
// [R3] output selections: ctrl1, ctrl2, or both
// [R4] poll input layout from vendor attribute two
// [R5] poll input path assemblies 120..131 select 0..11
// [R6] input lengths 6, 14 or 10 bytes
// [R7] short layouts: gross/net, integer/float value
// [R8] strobe layout from path assemblies 140..143
// [R9] strobe payload value, status, digital inputs
// [R10] cyclic layout from vendor attribute four
// [R11] cyclic layout from path assemblies 160..163
// [R12] cyclic payload value, status, digital inputs
// [R13] least significant byte first, single float
package ciam_pkg;
	// ==========================================================
	// apb register byte offsets
	localparam logic [7:0] ADDR_SEL_POLL_OUT = 8'h00;
	localparam logic [7:0] ADDR_SEL_POLL_IN = 8'h04;
	localparam logic [7:0] ADDR_SEL_STROBE = 8'h08;
	localparam logic [7:0] ADDR_SEL_COS = 8'h0C;
	localparam logic [7:0] ADDR_PATH_POLL_OUT = 8'h10;
	localparam logic [7:0] ADDR_PATH_POLL_IN = 8'h14;
	localparam logic [7:0] ADDR_PATH_STROBE = 8'h18;
	localparam logic [7:0] ADDR_PATH_COS = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	// ==========================================================
	// assembly path word: class [23:16], instance [15:8], attribute [7:0]
	localparam logic [7:0] PATH_CLASS = 8'h04;
	localparam logic [7:0] PATH_ATTR = 8'h02;
	localparam logic [7:0] ASM_POLL_OUT_BASE = 8'h64;
	localparam logic [7:0] ASM_POLL_IN_BASE = 8'h78;
	localparam logic [7:0] ASM_STROBE_BASE = 8'h8C;
	localparam logic [7:0] ASM_COS_BASE = 8'hA0;
	localparam logic [3:0] MAX_SEL_POLL_OUT = 4'h2;
	localparam logic [3:0] MAX_SEL_POLL_IN = 4'hB;
	localparam logic [3:0] MAX_SEL_SHORT = 4'h3;
	localparam logic [3:0] SEL_RESET = 4'h0;
	// ==========================================================
	// payload lengths in bytes
	localparam logic [3:0] LEN_SHORT = 4'h6;
	localparam logic [3:0] LEN_PEAKS = 4'hE;
	localparam logic [3:0] LEN_PP = 4'hA;
	localparam logic [1:0] LEN_OUT_ONE = 2'h1;
	localparam logic [1:0] LEN_OUT_TWO = 2'h2;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 9;
	// ==========================================================
	// message kinds
	typedef enum logic [1:0] {
		CIAM_KIND_POLL,
		CIAM_KIND_STROBE,
		CIAM_KIND_COS
	} ciam_kind_t;
endpackage

/* File: rtl/ciam_top.sv */
// cyclic payload builder and parser with apb selection registers
// assumes measurement values and byte streams come from same-clock logic
`timescale 1ns/10ps

// ==========================================================
// synchronous fifo with valid/ready on both sides
module ciam_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// fill side
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	// drain side
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_r;
	logic [AW-1:0] rptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	assign o_in_ready = (count_r != (AW+1)'(DEPTH));
	assign o_out_valid = (count_r != '0);
	assign o_out_data = mem[rptr_r];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem[wptr_r] <= i_in_data;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			wptr_r <= '0;
			rptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (pop) begin
				rptr_r <= rptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule

// ==========================================================
// top: selection registers, input payload framer, output payload parser
module ciam_top (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// measured values
	input wire logic [31:0] i_gross_int,
	input wire logic [31:0] i_gross_flt,
	input wire logic [31:0] i_net_int,
	input wire logic [31:0] i_net_flt,
	input wire logic [31:0] i_peak_min_int,
	input wire logic [31:0] i_peak_min_flt,
	input wire logic [31:0] i_peak_max_int,
	input wire logic [31:0] i_peak_max_flt,
	input wire logic [31:0] i_peak_pp_int,
	input wire logic [31:0] i_peak_pp_flt,
	input wire logic [7:0] i_measurement_status_byte,
	input wire logic [7:0] i_digital_input_state_byte,
	// input payload request
	input wire logic i_tx_req,
	input wire logic [1:0] i_tx_kind,
	output logic o_tx_busy,
	// input payload byte stream
	output logic o_tx_valid,
	output logic [7:0] o_tx_data,
	output logic o_tx_last,
	input wire logic i_tx_ready,
	// output payload byte stream
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	input wire logic i_rx_last,
	output logic o_rx_ready,
	// parsed control bytes
	output logic [7:0] o_first_control_byte,
	output logic [7:0] o_second_control_byte,
	output logic o_rx_done,
	output logic o_rx_len_err
);
	typedef enum logic {
		CIAM_IDLE,
		CIAM_SEND
	} ciam_state_t;

	logic [3:0] sel_out_r;
	logic [3:0] sel_in_r;
	logic [3:0] sel_strobe_r;
	logic [3:0] sel_cos_r;
	logic [31:0] rdata_nxt;
	logic slverr_nxt;
	logic [3:0] wsel_nxt;
	logic wr_ok;
	logic setup;
	logic wr_acc;
	logic [7:0] path_inst;
	logic path_form;

	// ==========================================================
	// apb: decode in setup, answer in access so read data is registered
	assign setup = i_psel && !i_penable;
	assign wr_acc = i_psel && i_penable && i_pwrite && !o_pslverr;
	assign path_inst = i_pwdata[15:8];
	assign path_form = (i_pwdata[23:16] == ciam_pkg::PATH_CLASS) && (i_pwdata[7:0] == ciam_pkg::PATH_ATTR);

	function automatic logic [31:0] path_of(input logic [7:0] base, input logic [3:0] sel);
		path_of = {8'h00, ciam_pkg::PATH_CLASS, 8'(base + 8'(sel)), ciam_pkg::PATH_ATTR};
	endfunction

	always_comb begin
		rdata_nxt = '0;
		slverr_nxt = 1'b0;
		wsel_nxt = i_pwdata[3:0];
		wr_ok = (i_pwdata[31:4] == '0);
		if (i_paddr == ciam_pkg::ADDR_SEL_POLL_OUT) begin
			rdata_nxt = {28'h0000000, sel_out_r};
			wr_ok = wr_ok && (i_pwdata[3:0] <= ciam_pkg::MAX_SEL_POLL_OUT);
		end else if (i_paddr == ciam_pkg::ADDR_SEL_POLL_IN) begin
			rdata_nxt = {28'h0000000, sel_in_r};
			wr_ok = wr_ok && (i_pwdata[3:0] <= ciam_pkg::MAX_SEL_POLL_IN);
		end else if (i_paddr == ciam_pkg::ADDR_SEL_STROBE) begin
			rdata_nxt = {28'h0000000, sel_strobe_r};
			wr_ok = wr_ok && (i_pwdata[3:0] <= ciam_pkg::MAX_SEL_SHORT);
		end else if (i_paddr == ciam_pkg::ADDR_SEL_COS) begin
			rdata_nxt = {28'h0000000, sel_cos_r};
			wr_ok = wr_ok && (i_pwdata[3:0] <= ciam_pkg::MAX_SEL_SHORT);
		end else if (i_paddr == ciam_pkg::ADDR_PATH_POLL_OUT) begin
			rdata_nxt = path_of(ciam_pkg::ASM_POLL_OUT_BASE, sel_out_r);
			wsel_nxt = 4'(path_inst - ciam_pkg::ASM_POLL_OUT_BASE);
			wr_ok = path_form && (path_inst >= ciam_pkg::ASM_POLL_OUT_BASE)
				&& (path_inst <= ciam_pkg::ASM_POLL_OUT_BASE + 8'(ciam_pkg::MAX_SEL_POLL_OUT));
		end else if (i_paddr == ciam_pkg::ADDR_PATH_POLL_IN) begin
			rdata_nxt = path_of(ciam_pkg::ASM_POLL_IN_BASE, sel_in_r);
			wsel_nxt = 4'(path_inst - ciam_pkg::ASM_POLL_IN_BASE);
			wr_ok = path_form && (path_inst >= ciam_pkg::ASM_POLL_IN_BASE)
				&& (path_inst <= ciam_pkg::ASM_POLL_IN_BASE + 8'(ciam_pkg::MAX_SEL_POLL_IN));
		end else if (i_paddr == ciam_pkg::ADDR_PATH_STROBE) begin
			rdata_nxt = path_of(ciam_pkg::ASM_STROBE_BASE, sel_strobe_r);
			wsel_nxt = 4'(path_inst - ciam_pkg::ASM_STROBE_BASE);
			wr_ok = path_form && (path_inst >= ciam_pkg::ASM_STROBE_BASE)
				&& (path_inst <= ciam_pkg::ASM_STROBE_BASE + 8'(ciam_pkg::MAX_SEL_SHORT));
		end else if (i_paddr == ciam_pkg::ADDR_PATH_COS) begin
			rdata_nxt = path_of(ciam_pkg::ASM_COS_BASE, sel_cos_r);
			wsel_nxt = 4'(path_inst - ciam_pkg::ASM_COS_BASE);
			wr_ok = path_form && (path_inst >= ciam_pkg::ASM_COS_BASE)
				&& (path_inst <= ciam_pkg::ASM_COS_BASE + 8'(ciam_pkg::MAX_SEL_SHORT));
		end else if (i_paddr == ciam_pkg::ADDR_STATUS) begin
			rdata_nxt = {31'h00000000, o_tx_busy};
			wr_ok = 1'b0;
		end else begin
			wr_ok = 1'b0;
			slverr_nxt = 1'b1;
		end
		// out-of-range selections and malformed paths are refused, not clipped
		if (i_pwrite && !wr_ok) begin
			slverr_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_prdata <= '0;
			o_pslverr <= 1'b0;
		end else if (setup) begin
			o_prdata <= i_pwrite ? 32'h00000000 : rdata_nxt;
			o_pslverr <= slverr_nxt;
		end
	end

	assign o_pready = i_psel && i_penable;

	// either the vendor attribute or the assembly path lands in one selection
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			sel_out_r <= ciam_pkg::SEL_RESET;
			sel_in_r <= ciam_pkg::SEL_RESET;
			sel_strobe_r <= ciam_pkg::SEL_RESET;
			sel_cos_r <= ciam_pkg::SEL_RESET;
		end else if (wr_acc) begin
			if (i_paddr == ciam_pkg::ADDR_SEL_POLL_OUT || i_paddr == ciam_pkg::ADDR_PATH_POLL_OUT) begin
				sel_out_r <= wsel_nxt; // [R1] [R2]
			end else if (i_paddr == ciam_pkg::ADDR_SEL_POLL_IN || i_paddr == ciam_pkg::ADDR_PATH_POLL_IN) begin
				sel_in_r <= wsel_nxt; // [R4] [R5]
			end else if (i_paddr == ciam_pkg::ADDR_SEL_STROBE || i_paddr == ciam_pkg::ADDR_PATH_STROBE) begin
				sel_strobe_r <= wsel_nxt; // [R8]
			end else if (i_paddr == ciam_pkg::ADDR_SEL_COS || i_paddr == ciam_pkg::ADDR_PATH_COS) begin
				sel_cos_r <= wsel_nxt; // [R10] [R11]
			end
		end
	end

	// ==========================================================
	// input payload framer: snapshot then shift bytes into the fifo
	ciam_state_t state_r;
	logic [111:0] shift_r;
	logic [3:0] left_r;
	logic [111:0] frame_nxt;
	logic [3:0] len_nxt;
	logic [3:0] sel_use;
	logic [31:0] value_sel;
	logic [31:0] pmin_sel;
	logic [31:0] pmax_sel;
	logic [31:0] pp_sel;
	logic fifo_in_ready;
	logic push;

	always_comb begin
		if (ciam_pkg::ciam_kind_t'(i_tx_kind) == ciam_pkg::CIAM_KIND_STROBE) begin
			sel_use = sel_strobe_r;
		end else if (ciam_pkg::ciam_kind_t'(i_tx_kind) == ciam_pkg::CIAM_KIND_COS) begin
			sel_use = sel_cos_r;
		end else begin
			sel_use = sel_in_r;
		end
		// bit 0 picks float, net is selections 2,3 and 8..11
		if (sel_use[0]) begin
			value_sel = (sel_use[1] && sel_use <= ciam_pkg::MAX_SEL_SHORT) || sel_use[3] ? i_net_flt : i_gross_flt; // [R7]
			pmin_sel = i_peak_min_flt;
			pmax_sel = i_peak_max_flt;
			pp_sel = i_peak_pp_flt;
		end else begin
			value_sel = (sel_use[1] && sel_use <= ciam_pkg::MAX_SEL_SHORT) || sel_use[3] ? i_net_int : i_gross_int; // [R7]
			pmin_sel = i_peak_min_int;
			pmax_sel = i_peak_max_int;
			pp_sel = i_peak_pp_int;
		end
		// byte 0 in bits [7:0]: least significant byte leaves first
		if (sel_use <= ciam_pkg::MAX_SEL_SHORT) begin
			len_nxt = ciam_pkg::LEN_SHORT; // [R6] [R9] [R12]
			frame_nxt = {64'h0, i_digital_input_state_byte, i_measurement_status_byte, value_sel}; // [R13]
		end else if (sel_use[1] == 1'b0) begin
			len_nxt = ciam_pkg::LEN_PEAKS; // [R6]
			frame_nxt = {i_digital_input_state_byte, i_measurement_status_byte, pmax_sel, pmin_sel, value_sel};
		end else begin
			len_nxt = ciam_pkg::LEN_PP; // [R6]
			frame_nxt = {32'h0, i_digital_input_state_byte, i_measurement_status_byte, pp_sel, value_sel};
		end
	end

	assign o_tx_busy = (state_r == CIAM_SEND);
	assign push = (state_r == CIAM_SEND) && fifo_in_ready;

	// requests arriving while a frame is still being queued are dropped
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			state_r <= CIAM_IDLE;
			shift_r <= '0;
			left_r <= '0;
		end else begin
			case (state_r)
				CIAM_IDLE: begin
					if (i_tx_req && i_tx_kind != 2'h3) begin
						shift_r <= frame_nxt;
						left_r <= len_nxt;
						state_r <= CIAM_SEND;
					end
				end
				CIAM_SEND: begin
					if (push) begin
						shift_r <= {8'h00, shift_r[111:8]}; // [R13]
						left_r <= left_r - 1'b1;
						if (left_r == 4'h1) begin
							state_r <= CIAM_IDLE;
						end
					end
				end
				default: state_r <= CIAM_IDLE;
			endcase
		end
	end

	ciam_fifo #(
		.WIDTH(ciam_pkg::FIFO_WIDTH),
		.DEPTH(ciam_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_in_valid(state_r == CIAM_SEND),
		.i_in_data({left_r == 4'h1, shift_r[7:0]}),
		.o_in_ready(fifo_in_ready),
		.o_out_valid(o_tx_valid),
		.o_out_data({o_tx_last, o_tx_data}),
		.i_out_ready(i_tx_ready)
	);

	// ==========================================================
	// output payload parser: control bytes commit only on a correct length
	logic [7:0] rx_b0_r;
	logic [1:0] rx_cnt_r;
	logic [1:0] rx_len;
	logic [1:0] rx_exp;

	assign o_rx_ready = 1'b1;
	assign rx_len = (rx_cnt_r == 2'h3) ? rx_cnt_r : rx_cnt_r + 1'b1;
	assign rx_exp = (sel_out_r == ciam_pkg::MAX_SEL_POLL_OUT) ? ciam_pkg::LEN_OUT_TWO : ciam_pkg::LEN_OUT_ONE;

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			rx_b0_r <= '0;
			rx_cnt_r <= '0;
			o_first_control_byte <= '0;
			o_second_control_byte <= '0;
			o_rx_done <= 1'b0;
			o_rx_len_err <= 1'b0;
		end else begin
			o_rx_done <= 1'b0;
			o_rx_len_err <= 1'b0;
			if (i_rx_valid) begin
				if (rx_cnt_r == 2'h0) begin
					rx_b0_r <= i_rx_data;
				end
				rx_cnt_r <= i_rx_last ? 2'h0 : rx_len;
				if (i_rx_last && rx_len != rx_exp) begin
					o_rx_len_err <= 1'b1;
				end else if (i_rx_last) begin
					o_rx_done <= 1'b1;
					if (sel_out_r == 4'h0) begin
						o_first_control_byte <= i_rx_data; // [R3]
					end else if (sel_out_r == 4'h1) begin
						o_second_control_byte <= i_rx_data; // [R3]
					end else begin
						o_first_control_byte <= rx_b0_r; // [R3]
						o_second_control_byte <= i_rx_data;
					end
				end
			end
		end
	end
endmodule

/* File: bench/ciam_top_sva.sv */
// checker on the mapper top ports, bound to every ciam_top
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module ciam_chk (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// apb
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic [7:0] i_paddr,
	input wire logic o_pready,
	input wire logic o_pslverr,
	// input payload side
	input wire logic i_tx_req,
	input wire logic [1:0] i_tx_kind,
	input wire logic o_tx_busy,
	input wire logic o_tx_valid,
	input wire logic [7:0] o_tx_data,
	input wire logic o_tx_last,
	input wire logic i_tx_ready,
	// output payload side
	input wire logic i_rx_valid,
	input wire logic i_rx_last,
	input wire logic [7:0] o_first_control_byte,
	input wire logic [7:0] o_second_control_byte,
	input wire logic o_rx_done,
	input wire logic o_rx_len_err
);
	// ==========================================================
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	logic [3:0] bc_r;
	logic take;
	assign take = i_tx_req && i_tx_kind != 2'h3 && !o_tx_busy;
	// bytes already handed over in the current payload
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) bc_r <= 4'h0;
		else if (o_tx_valid && i_tx_ready) bc_r <= o_tx_last ? 4'h0 : bc_r + 4'h1;
	end
	a_pready_comb: assert property (o_pready == (i_psel && i_penable)) else $error("pready wrong");
	a_err_unmapped: assert property (i_psel && !i_penable && i_paddr > 8'h20 |=> o_pslverr) else $error("no slverr");
	a_busy_start: assert property (take |=> o_tx_busy) else $error("request not taken");
	a_kind_drop: assert property (i_tx_req && i_tx_kind == 2'h3 && !o_tx_busy |=> !o_tx_busy) else $error("kind 3 taken");
	a_first_byte: assert property (take && !o_tx_valid |-> ##2 o_tx_valid) else $error("first byte late");
	a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last))
		else $error("byte not held");
	a_frame_len: assert property (o_tx_valid && i_tx_ready && o_tx_last |-> bc_r inside {4'h5, 4'h9, 4'hD})
		else $error("bad payload length");
	a_rx_answer: assert property (i_rx_valid && i_rx_last |=> o_rx_done || o_rx_len_err) else $error("no rx answer");
	a_done_excl: assert property (!(o_rx_done && o_rx_len_err)) else $error("done with error");
	a_ctrl_cause: assert property ($changed(o_first_control_byte) || $changed(o_second_control_byte) |-> o_rx_done)
		else $error("control changed alone");
	a_err_keep: assert property (o_rx_len_err |-> $stable(o_first_control_byte) && $stable(o_second_control_byte))
		else $error("control changed on error");
	c_take: cover property (take);
	c_len_err: cover property (o_rx_len_err);
	c_stall: cover property (o_tx_valid && !i_tx_ready ##1 o_tx_valid);
endmodule
bind ciam_top ciam_chk u_chk (.*);

/* File: bench/ciam_far_end.sv */
// master-side model: drains input payloads, sends output payloads
// assumes the bench sets stall and calls send
`timescale 1ns/10ps
module ciam_far_end (
	// clock
	input wire logic i_sys_clk,
	// payload from the block
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_last,
	output logic o_tx_ready,
	// payload to the block
	output logic o_rx_valid,
	output logic [7:0] o_rx_data,
	output logic o_rx_last
);
	// ==========================================================
	logic stall = 1'b0;
	logic ph = 1'b0;
	logic [7:0] q[$];
	int frames = 0;
	initial begin
		o_rx_valid = 1'b0;
		o_rx_data = 8'hA5;
		o_rx_last = 1'b0;
	end
	// ready on every other cycle so the block always meets a slow reader
	assign o_tx_ready = !stall && ph;
	always @(posedge i_sys_clk) begin
		ph <= ~ph;
		if (i_tx_valid && o_tx_ready) begin
			q.push_back(i_tx_data);
			if (i_tx_last) frames <= frames + 1;
		end
	end
	// the block accepts every byte, so one byte goes per edge
	task send(input logic [7:0] b0, input logic [7:0] b1, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge i_sys_clk);
			o_rx_valid <= 1'b1;
			o_rx_data <= i ? b1 : b0;
			o_rx_last <= i == n - 1;
		end
		@(posedge i_sys_clk);
		o_rx_valid <= 1'b0;
		o_rx_last <= 1'b0;
		o_rx_data <= ~o_rx_data;
	endtask
endmodule

/* File: bench/test_cyclic_io_assembly_mapper.sv */
// self-checking bench for the cyclic io assembly mapper
// assumes the far-end model as master and the bound checker
`timescale 1ns/10ps
module test_cyclic_io_assembly_mapper;
	// ==========================================================
	logic i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, i_tx_req = 1'b0;
	logic [7:0] i_paddr = 8'h00, o_tx_data, i_rx_data, o_first_control_byte, o_second_control_byte;
	logic [31:0] i_pwdata = 32'h0, o_prdata, rdv, mv[10];
	logic [1:0] i_tx_kind = 2'h0;
	logic o_pready, o_pslverr, o_tx_busy, o_tx_valid, o_tx_last, i_tx_ready, i_rx_valid, i_rx_last;
	logic o_rx_ready, o_rx_done, o_rx_len_err, erv, lerr_seen = 1'b0;
	logic [7:0] exq[$];
	int err_count = 0;
	int compares = 0;
	always #2.5 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) if (o_rx_len_err === 1'b1) lerr_seen <= 1'b1;
	ciam_top DUT (.*, .i_gross_int(mv[0]), .i_gross_flt(mv[1]), .i_net_int(mv[2]), .i_net_flt(mv[3]),
		.i_peak_min_int(mv[4]), .i_peak_min_flt(mv[5]), .i_peak_max_int(mv[6]), .i_peak_max_flt(mv[7]),
		.i_peak_pp_int(mv[8]), .i_peak_pp_flt(mv[9]), .i_measurement_status_byte(8'h5A),
		.i_digital_input_state_byte(8'hC3));
	ciam_far_end far (.i_sys_clk, .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .i_tx_last(o_tx_last),
		.o_tx_ready(i_tx_ready), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data), .o_rx_last(i_rx_last));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			$display("mismatch %0t seen %h exp %h", $time, seen, exp);
			err_count++;
		end
	endtask
	task tally_and_finish;
		if (err_count == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task hang;
		err_count++;
		tally_and_finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_sys_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_sys_clk);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 20);
		if (n >= 20) hang;
		rdv = o_prdata;
		erv = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	function logic [31:0] pth(input logic [7:0] inst);
		return {8'h00, ciam_pkg::PATH_CLASS, inst, ciam_pkg::PATH_ATTR};
	endfunction
	task push32(input logic [31:0] v);
		for (int i = 0; i < 4; i++) exq.push_back(v[8*i+:8]);
	endtask
	// expected payload: value, optional peaks, status, digital inputs
	task mk(input logic [1:0] k, input logic [3:0] s);
		logic net;
		exq.delete();
		net = s == 4'h2 || s == 4'h3 || s >= 4'h8;
		push32(mv[2 * net + s[0]]);
		if (k == 2'h0 && s >= 4'h4 && s[1]) push32(mv[8 + s[0]]);
		if (k == 2'h0 && s >= 4'h4 && !s[1]) begin
			push32(mv[4 + s[0]]);
			push32(mv[6 + s[0]]);
		end
		exq.push_back(8'h5A);
		exq.push_back(8'hC3);
	endtask
	task pulse(input logic [1:0] k);
		@(posedge i_sys_clk);
		i_tx_req <= 1'b1;
		i_tx_kind <= k;
		@(posedge i_sys_clk);
		i_tx_req <= 1'b0;
	endtask
	task wait_frames(input int n);
		for (int i = 0; i < 3000 && far.frames < n; i++) @(posedge i_sys_clk);
		if (far.frames < n) hang;
	endtask
	task run_frame(input logic [1:0] k, input logic [3:0] s);
		mk(k, s);
		far.q.delete();
		pulse(k);
		wait_frames(far.frames + 1);
		chk(far.q.size(), exq.size());
		foreach (exq[i]) chk(far.q[i], exq[i]);
	endtask
	task t_reset;
		for (int a = 0; a < 4; a++) begin
			apb(1'b0, 8'(4 * a), 32'h0);
			chk(rdv, 32'h0);
		end
		apb(1'b0, ciam_pkg::ADDR_STATUS, 32'h0);
		chk(rdv, 32'h0);
	endtask
	task t_poll_in;
		for (int s = 0; s < 12; s++) begin
			apb(1'b1, ciam_pkg::ADDR_SEL_POLL_IN, s);
			run_frame(2'h0, 4'(s));
		end
		apb(1'b1, ciam_pkg::ADDR_PATH_POLL_IN, pth(ciam_pkg::ASM_POLL_IN_BASE + 8'h5));
		chk(erv, 1'b0);
		run_frame(2'h0, 4'h5);
	endtask
	task t_short;
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, ciam_pkg::ADDR_PATH_STROBE, pth(ciam_pkg::ASM_STROBE_BASE + 8'(s)));
			run_frame(2'h1, 4'(s));
			apb(1'b1, ciam_pkg::ADDR_SEL_COS, s);
			run_frame(2'h2, 4'(s));
			apb(1'b1, ciam_pkg::ADDR_PATH_COS, pth(ciam_pkg::ASM_COS_BASE + 8'(3 - s)));
			run_frame(2'h2, 4'(3 - s));
		end
	endtask
	task t_out;
		apb(1'b1, ciam_pkg::ADDR_SEL_POLL_OUT, 32'h0);
		chk(o_rx_ready, 1'b1);
		far.send(8'h3C, 8'h00, 1);
		apb(1'b1, ciam_pkg::ADDR_SEL_POLL_OUT, 32'h1);
		chk(o_first_control_byte, 8'h3C);
		far.send(8'h96, 8'h00, 1);
		apb(1'b1, ciam_pkg::ADDR_PATH_POLL_OUT, pth(ciam_pkg::ASM_POLL_OUT_BASE + 8'h2));
		chk(o_second_control_byte, 8'h96);
		far.send(8'h71, 8'hE8, 2);
		repeat (3) @(posedge i_sys_clk);
		chk({o_first_control_byte, o_second_control_byte}, 16'h71E8);
		far.send(8'h11, 8'h00, 1);
		repeat (3) @(posedge i_sys_clk);
		chk({lerr_seen, o_first_control_byte}, 9'h171);
	endtask
	// second frame fills the buffer and holds the framer busy while the reader stalls
	task t_fifo;
		apb(1'b1, ciam_pkg::ADDR_SEL_POLL_IN, 32'h4);
		mk(2'h0, 4'h4);
		far.q.delete();
		far.stall <= 1'b1;
		pulse(2'h0);
		// busy rises only after the request edge, so let one edge pass first
		for (int i = 0; i < 100 && (i == 0 || o_tx_busy !== 1'b0); i++) @(posedge i_sys_clk);
		if (o_tx_busy !== 1'b0) hang;
		pulse(2'h0);
		repeat (8) @(posedge i_sys_clk);
		pulse(2'h1);
		repeat (30) @(posedge i_sys_clk);
		chk({o_tx_busy, o_tx_valid}, 2'h3);
		far.stall <= 1'b0;
		wait_frames(far.frames + 2);
		repeat (30) @(posedge i_sys_clk);
		chk(far.q.size(), 28);
		for (int i = 0; i < 28; i++) chk(far.q[i], exq[i % 14]);
		chk({o_tx_busy, o_tx_valid}, 2'h0);
	endtask
	task t_refuse;
		apb(1'b0, 8'h40, 32'h0);
		chk(erv, 1'b1);
		chk(rdv, 32'h0);
		apb(1'b1, ciam_pkg::ADDR_SEL_POLL_IN, 32'hC);
		chk(erv, 1'b1);
		apb(1'b1, ciam_pkg::ADDR_PATH_POLL_IN, 32'h00057902);
		chk(erv, 1'b1);
		apb(1'b1, ciam_pkg::ADDR_PATH_STROBE, pth(ciam_pkg::ASM_STROBE_BASE + 8'h4));
		chk(erv, 1'b1);
		apb(1'b0, ciam_pkg::ADDR_SEL_POLL_IN, 32'h0);
		chk(rdv, 32'h4);
		pulse(2'h3);
		repeat (4) @(posedge i_sys_clk);
		chk({o_tx_busy, o_tx_valid}, 2'h0);
	endtask
	initial begin
		for (int i = 0; i < 10; i++) mv[i] = 32'h03020100 + 32'h10101010 * i;
		repeat (16) @(posedge i_sys_clk);
		i_sys_rst <= 1'b0;
		t_reset;
		t_poll_in;
		t_short;
		t_out;
		t_fifo;
		t_refuse;
		tally_and_finish;
	end
endmodule
